// ### src/vdiu_pkg.sv
// constants and types shared by the video decoder interrupt unit
package vdiu_pkg;
  // register addresses (user map control lives in the user map)
  localparam logic [7:0] ADDR_USR_CTRL = 8'h0e;
  localparam logic [7:0] ADDR_PIN_CFG  = 8'h40;
  localparam logic [7:0] ADDR_STAT1    = 8'h42;
  localparam logic [7:0] ADDR_CLR1     = 8'h43;
  localparam logic [7:0] ADDR_MASK1    = 8'h44;
  localparam logic [1:0] SUBMAP_INTR   = 2'h1;
  // field positions
  localparam int SUBMAP_LSB = 0;
  localparam int STYLE_LSB  = 0;
  localparam int FORCE_BIT  = 2;
  localparam int CPSEL_LSB  = 4;
  localparam int LEN_LSB    = 6;
  localparam int LOCK_BIT   = 0;
  localparam int UNLOCK_BIT = 1;
  localparam int FRCHG_BIT  = 5;
  localparam int CP_BIT     = 6;
  // writable / implemented bits
  localparam logic [7:0] STAT_USED     = 8'h63;
  localparam logic [7:0] PIN_CFG_WMASK = 8'hf7;
  localparam logic [7:0] USR_CTRL_WMASK = 8'h03;
  // reset values
  localparam logic [7:0] PIN_CFG_RST  = 8'h00;
  localparam logic [7:0] MASK_RST     = 8'h00;
  localparam logic [7:0] USR_CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST     = 8'h00;
  // drive style and pulse length encodings
  localparam logic [1:0] STYLE_OD   = 2'h0;
  localparam logic [1:0] STYLE_LOW  = 2'h1;
  localparam logic [1:0] STYLE_HIGH = 2'h2;
  localparam logic [1:0] LEN_SHORT  = 2'h0;
  localparam logic [1:0] LEN_MID    = 2'h1;
  localparam logic [1:0] LEN_LONG   = 2'h2;
  localparam logic [1:0] LEN_HOLD   = 2'h3;
  // pulse lengths in crystal periods; clk is the crystal clock
  localparam int DUR_SHORT_CRYSTAL_CLOCK = 3;
  localparam int DUR_MID_CRYSTAL_CLOCK   = 15;
  localparam int DUR_LONG_CRYSTAL_CLOCK  = 63;
  localparam int CLK_PER_CRYSTAL_CLOCK   = 1;
  localparam int DUR_SHORT_CYC  = DUR_SHORT_CRYSTAL_CLOCK * CLK_PER_CRYSTAL_CLOCK;
  localparam int DUR_MID_CYC    = DUR_MID_CRYSTAL_CLOCK * CLK_PER_CRYSTAL_CLOCK;
  localparam int DUR_LONG_CYC   = DUR_LONG_CRYSTAL_CLOCK * CLK_PER_CRYSTAL_CLOCK;
  // serial port slave address, value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEF = 7'h20;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h3,
    ST_SUB  = 4'h2,
    ST_SACK = 4'h6,
    ST_WDAT = 4'h7,
    ST_WACK = 4'h5,
    ST_RDAT = 4'hb,
    ST_RACK = 4'hf
  } vdiu_i2c_st_type;
endpackage

// ### src/vdiu_pin_if.sv
// interrupt pin request and configuration carrier
`timescale 1ns/1ps
`default_nettype none
interface vdiu_pin_if;
  logic [1:0] style;
  logic [1:0] length;
  logic       level;
  modport ctl (output style, output length, output level);
  modport drv (input style, input length, input level);
endinterface
`default_nettype wire

// ### src/vdiu_irq_pin.sv
// interrupt pin driver: pulse length and drive style
`timescale 1ns/1ps
`default_nettype none
module vdiu_irq_pin #(
  parameter int CNT_W     = 6,
  parameter int DUR_SHORT = vdiu_pkg::DUR_SHORT_CYC,
  parameter int DUR_MID   = vdiu_pkg::DUR_MID_CYC,
  parameter int DUR_LONG  = vdiu_pkg::DUR_LONG_CYC
) (
  input  wire logic    clk,
  input  wire logic    sys_rst,
  vdiu_pin_if.drv      pin,
  output var  logic    irq_o,
  output var  logic    irq_oe
);
  logic             level_p_r;
  logic             act_r;
  logic             act_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] dur_sel;

  always_comb begin
    case (pin.length)
      vdiu_pkg::LEN_SHORT: dur_sel = CNT_W'(DUR_SHORT - 1);
      vdiu_pkg::LEN_MID:   dur_sel = CNT_W'(DUR_MID - 1);
      default:             dur_sel = CNT_W'(DUR_LONG - 1);
    endcase
  end

  // a new pulse starts only on a rising request; retriggers during a pulse are dropped
  always_comb begin
    act_nxt = act_r;
    cnt_nxt = cnt_r;
    if (pin.length == vdiu_pkg::LEN_HOLD) begin
      act_nxt = pin.level;
      cnt_nxt = '0;
    end else if (!act_r) begin
      if (pin.level && !level_p_r) begin
        act_nxt = 1'b1;
        cnt_nxt = dur_sel;
      end
    end else if (cnt_r == '0) begin
      act_nxt = 1'b0;
    end else begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_p_r <= 1'b0;
      act_r     <= 1'b0;
      cnt_r     <= '0;
    end else begin
      level_p_r <= pin.level;
      act_r     <= act_nxt;
      cnt_r     <= cnt_nxt;
    end
  end

  // reserved style falls back to open drain so the pin never fights a pull-up
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_o  <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      case (pin.style)
        vdiu_pkg::STYLE_LOW: begin
          irq_o  <= !act_nxt;
          irq_oe <= 1'b1;
        end
        vdiu_pkg::STYLE_HIGH: begin
          irq_o  <= act_nxt;
          irq_oe <= 1'b1;
        end
        default: begin
          irq_o  <= 1'b0;
          irq_oe <= act_nxt;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  drive_style_a: assert property (pin.style == vdiu_pkg::STYLE_LOW |=> irq_oe && (irq_o == !act_r))
    else $error("drive low style wrong");
  pulse_three_a: assert property ($rose(act_r) && pin.length == 2'h0 |-> act_r [*3] ##1 !act_r)
    else $error("short pulse not three cycles");
  hold_level_a: assert property (pin.length == 2'h3 |=> act_r == $past(pin.level))
    else $error("hold mode does not follow request");
  pulse_start_a: assert property ($rose(pin.level) && !act_r && pin.length != 2'h3 |=> act_r)
    else $error("request did not start pulse");
endmodule
`default_nettype wire

// ### src/vdiu_core.sv
// video decoder interrupt unit: serial register port, event flags, pin control
`timescale 1ns/1ps
`default_nettype none
module vdiu_core #(
  parameter logic [6:0] DEV_ADDR = vdiu_pkg::DEV_ADDR_DEF
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var  logic sda_o,
  output var  logic sda_oe,
  input  wire logic lock_state,
  input  wire logic freerun_state,
  input  wire logic pseudo_sync_det,
  input  wire logic colour_stripe_det,
  output var  logic irq_o,
  output var  logic irq_oe
);
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic       scl_f_r;
  logic       sda_f_r;
  logic       scl_p_r;
  logic       sda_p_r;
  logic       start_det;
  logic       stop_det;
  logic       scl_rise;
  logic       scl_fall;

  vdiu_pkg::vdiu_i2c_st_type st_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] tx_sh_r;
  logic       rw_r;
  logic       nack_r;
  logic [7:0] ptr_r;
  logic       wr_stb_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [7:0] rd_data;

  logic [7:0] usr_ctrl_r;
  logic [7:0] pin_cfg_r;
  logic [7:0] mask_r;
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] clr_vec;
  logic [7:0] ev_vec;
  logic       intr_map;
  logic [1:0] cp_sel;
  logic       cp_hit;
  logic       lock_p_r;
  logic       fr_p_r;
  logic       cp_p_r;

  // three-stage pin synchronisers; a level is taken once stages two and three agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_i};
      sda_s_r <= {sda_s_r[1:0], sda_i};
      if (scl_s_r[1] == scl_s_r[2]) begin
        scl_f_r <= scl_s_r[2];
      end
      if (sda_s_r[1] == sda_s_r[2]) begin
        sda_f_r <= sda_s_r[2];
      end
      scl_p_r <= scl_f_r;
      sda_p_r <= sda_f_r;
    end
  end

  assign start_det = scl_f_r && scl_p_r && sda_p_r && !sda_f_r;
  assign stop_det  = scl_f_r && scl_p_r && !sda_p_r && sda_f_r;
  assign scl_rise  = scl_f_r && !scl_p_r;
  assign scl_fall  = !scl_f_r && scl_p_r;

  assign intr_map = usr_ctrl_r[vdiu_pkg::SUBMAP_LSB +: 2] == vdiu_pkg::SUBMAP_INTR;

  // read side: clear register is write-only, unmapped reads give zero
  always_comb begin
    rd_data = 8'h00;
    if (ptr_r == vdiu_pkg::ADDR_USR_CTRL) begin
      rd_data = usr_ctrl_r;
    end else if (intr_map) begin
      case (ptr_r)
        vdiu_pkg::ADDR_PIN_CFG: rd_data = pin_cfg_r;
        vdiu_pkg::ADDR_STAT1:   rd_data = stat_r;
        vdiu_pkg::ADDR_MASK1:   rd_data = mask_r;
        default:                rd_data = 8'h00;
      endcase
    end
  end

  // serial slave: address, sub-address, then data bytes with auto-increment
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r      <= vdiu_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      rx_sh_r   <= 8'h00;
      tx_sh_r   <= 8'h00;
      rw_r      <= 1'b0;
      nack_r    <= 1'b0;
      ptr_r     <= 8'h00;
      sda_oe    <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (start_det) begin
        st_r      <= vdiu_pkg::ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe    <= 1'b0;
      end else if (stop_det) begin
        st_r   <= vdiu_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        rx_sh_r   <= {rx_sh_r[6:0], sda_f_r};
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (st_r == vdiu_pkg::ST_RACK) begin
          nack_r <= sda_f_r;
        end
      end else if (scl_fall) begin
        case (st_r)
          vdiu_pkg::ST_ADDR: begin
            if (bit_cnt_r == 4'h8) begin
              if (rx_sh_r[7:1] == DEV_ADDR) begin
                st_r   <= vdiu_pkg::ST_AACK;
                rw_r   <= rx_sh_r[0];
                sda_oe <= 1'b1;
              end else begin
                st_r <= vdiu_pkg::ST_IDLE;
              end
            end
          end
          vdiu_pkg::ST_AACK: begin
            bit_cnt_r <= 4'h0;
            if (rw_r) begin
              st_r    <= vdiu_pkg::ST_RDAT;
              tx_sh_r <= rd_data;
              sda_oe  <= !rd_data[7];
              ptr_r   <= ptr_r + 8'h01;
            end else begin
              st_r   <= vdiu_pkg::ST_SUB;
              sda_oe <= 1'b0;
            end
          end
          vdiu_pkg::ST_SUB: begin
            if (bit_cnt_r == 4'h8) begin
              ptr_r  <= rx_sh_r;
              st_r   <= vdiu_pkg::ST_SACK;
              sda_oe <= 1'b1;
            end
          end
          vdiu_pkg::ST_WDAT: begin
            if (bit_cnt_r == 4'h8) begin
              wr_stb_r  <= 1'b1;
              wr_addr_r <= ptr_r;
              wr_data_r <= rx_sh_r;
              ptr_r     <= ptr_r + 8'h01;
              st_r      <= vdiu_pkg::ST_WACK;
              sda_oe    <= 1'b1;
            end
          end
          vdiu_pkg::ST_SACK, vdiu_pkg::ST_WACK: begin
            st_r      <= vdiu_pkg::ST_WDAT;
            bit_cnt_r <= 4'h0;
            sda_oe    <= 1'b0;
          end
          vdiu_pkg::ST_RDAT: begin
            if (bit_cnt_r == 4'h8) begin
              st_r   <= vdiu_pkg::ST_RACK;
              sda_oe <= 1'b0;
            end else begin
              tx_sh_r <= {tx_sh_r[6:0], 1'b0};
              sda_oe  <= !tx_sh_r[6];
            end
          end
          vdiu_pkg::ST_RACK: begin
            bit_cnt_r <= 4'h0;
            if (nack_r) begin
              st_r <= vdiu_pkg::ST_IDLE;
            end else begin
              st_r    <= vdiu_pkg::ST_RDAT;
              tx_sh_r <= rd_data;
              sda_oe  <= !rd_data[7];
              ptr_r   <= ptr_r + 8'h01;
            end
          end
          default: st_r <= vdiu_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // the data line is only ever pulled low
  always_ff @(posedge clk) begin
    sda_o <= 1'b0;
  end

  // user map control is reachable from every sub map
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      usr_ctrl_r <= vdiu_pkg::USR_CTRL_RST;
    end else if (wr_stb_r && wr_addr_r == vdiu_pkg::ADDR_USR_CTRL) begin
      usr_ctrl_r <= wr_data_r & vdiu_pkg::USR_CTRL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_cfg_r <= vdiu_pkg::PIN_CFG_RST;
      mask_r    <= vdiu_pkg::MASK_RST;
    end else if (wr_stb_r && intr_map) begin
      if (wr_addr_r == vdiu_pkg::ADDR_PIN_CFG) begin
        pin_cfg_r <= wr_data_r & vdiu_pkg::PIN_CFG_WMASK;
      end
      if (wr_addr_r == vdiu_pkg::ADDR_MASK1) begin
        mask_r <= wr_data_r & vdiu_pkg::STAT_USED;
      end
    end
  end

  // edge history follows the inputs through reset, so no false event at release
  always_ff @(posedge clk) begin
    lock_p_r <= lock_state;
    fr_p_r   <= freerun_state;
    cp_p_r   <= cp_hit;
  end

  assign cp_sel = pin_cfg_r[vdiu_pkg::CPSEL_LSB +: 2];
  assign cp_hit = (cp_sel[0] && pseudo_sync_det) || (cp_sel[1] && colour_stripe_det);

  always_comb begin
    ev_vec = 8'h00;
    ev_vec[vdiu_pkg::LOCK_BIT]   = lock_state && !lock_p_r;
    ev_vec[vdiu_pkg::UNLOCK_BIT] = !lock_state && lock_p_r;
    ev_vec[vdiu_pkg::FRCHG_BIT]  = freerun_state != fr_p_r;
    ev_vec[vdiu_pkg::CP_BIT]     = cp_hit && !cp_p_r;
  end

  // a write to status itself is ignored; only the clear register removes flags
  assign clr_vec = (wr_stb_r && intr_map && wr_addr_r == vdiu_pkg::ADDR_CLR1)
                   ? (wr_data_r & vdiu_pkg::STAT_USED) : 8'h00;
  // a new event in the clearing cycle wins over the clear
  assign stat_nxt = (stat_r & ~clr_vec) | ev_vec;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_r <= vdiu_pkg::STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  vdiu_pin_if pin_bus ();

  assign pin_bus.style  = pin_cfg_r[vdiu_pkg::STYLE_LSB +: 2];
  assign pin_bus.length = pin_cfg_r[vdiu_pkg::LEN_LSB +: 2];
  // manual bit acts like one more unmasked source
  assign pin_bus.level  = (|(stat_r & mask_r)) || pin_cfg_r[vdiu_pkg::FORCE_BIT];

  vdiu_irq_pin u_pin (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     (pin_bus.drv),
    .irq_o   (irq_o),
    .irq_oe  (irq_oe)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  lock_gain_a: assert property ($rose(lock_state) |=> stat_r[0])
    else $error("lock gained not flagged");
  lock_loss_a: assert property ($fell(lock_state) |=> stat_r[1])
    else $error("lock lost not flagged");
  freerun_chg_a: assert property ($changed(freerun_state) |=> stat_r[5])
    else $error("free-run change not flagged");
  cp_either_a: assert property (cp_sel == 2'h3 && $rose(pseudo_sync_det)
                                && !$past(colour_stripe_det) |=> stat_r[6])
    else $error("copy protect detection not flagged");
  cp_select_a: assert property (cp_sel == 2'h2 && !colour_stripe_det && !stat_r[6]
                                && !clr_vec[6] |=> !stat_r[6])
    else $error("unselected detection raised flag");
  status_ro_a: assert property ($fell(stat_r[0]) |-> $past(clr_vec[0]))
    else $error("status flag dropped without clear");
  clear_bit_a: assert property (clr_vec[1] && !ev_vec[1] |=> !stat_r[1])
    else $error("clear write did not clear flag");
  manual_irq_a: assert property ($rose(pin_cfg_r[2]) && pin_cfg_r[7:6] == 2'h3
                                 && pin_cfg_r[1:0] != 2'h2 |-> ##[1:2] (irq_oe && !irq_o))
    else $error("manual interrupt not driven");
endmodule
`default_nettype wire

// ### testbench/vdiu_host_model.sv
// host side model: two-wire serial master that reaches the register port
`timescale 1ns/1ps
`default_nettype none
module vdiu_host_model #(
  parameter logic [6:0] DEV = vdiu_pkg::DEV_ADDR_DEF
) (
  input  wire logic clk,
  input  wire logic sda_in,
  output var  logic scl,
  output var  logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // sda moves mid-low, clear of the device's edge filter and its ack release
  task automatic bit_io(input logic b, output logic r);
    hold(5);
    sda_pull = !b;
    hold(5);
    scl = 1'b1;
    hold(5);
    r = sda_in;
    hold(5);
    scl = 1'b0;
  endtask
  // serves as first and repeated start alike
  task automatic start_c();
    hold(5);
    sda_pull = 1'b0;
    hold(5);
    scl = 1'b1;
    hold(10);
    sda_pull = 1'b1;
    hold(10);
    scl = 1'b0;
  endtask
  task automatic stop_c();
    hold(5);
    sda_pull = 1'b1;
    hold(5);
    scl = 1'b1;
    hold(10);
    sda_pull = 1'b0;
    hold(10);
  endtask
  // ninth bit is always released: device ack on writes, host nack on reads
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, a);
    ack = !a;
  endtask
  // whole sub-address and data bytes; clear bits only where the host wants it
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    start_c();
    byte_io({DEV, 1'b0}, q, a0);
    byte_io(addr, q, a1);
    byte_io(data, q, a2);
    stop_c();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start_c();
    byte_io({DEV, 1'b0}, q, a0);
    byte_io(addr, q, a1);
    start_c();
    byte_io({DEV, 1'b1}, q, a2);
    byte_io(8'hff, data, a3);
    stop_c();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// ### testbench/vdiu_core_tb.sv
// self-checking bench for the video decoder interrupt unit
`timescale 1ns/1ps
`default_nettype none
module vdiu_core_tb;
  logic       clk;
  logic       sys_rst;
  logic       lock_state;
  logic       freerun_state;
  logic       pseudo_sync_det;
  logic       colour_stripe_det;
  logic       scl;
  logic       host_pull;
  logic       sda_o;
  logic       sda_oe;
  logic       irq_o;
  logic       irq_oe;
  logic [1:0] cur_style;
  logic [7:0] rd;
  logic       ok;
  int         n_fail;
  int         checks;
  int         cycles;
  int         n;
  int         durs[3];
  // pulled-up serial data line, low when either side pulls
  wire logic sda_w = !(host_pull || (sda_oe && !sda_o));
  vdiu_core #(.DEV_ADDR(vdiu_pkg::DEV_ADDR_DEF)) dut (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .scl_i             (scl),
    .sda_i             (sda_w),
    .sda_o             (sda_o),
    .sda_oe            (sda_oe),
    .lock_state        (lock_state),
    .freerun_state     (freerun_state),
    .pseudo_sync_det   (pseudo_sync_det),
    .colour_stripe_det (colour_stripe_det),
    .irq_o             (irq_o),
    .irq_oe            (irq_oe)
  );
  vdiu_host_model #(.DEV(vdiu_pkg::DEV_ADDR_DEF)) host (
    .clk      (clk),
    .sda_in   (sda_w),
    .scl      (scl),
    .sda_pull (host_pull)
  );
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  task automatic close_out();
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // about 37k cycles expected; ceiling leaves headroom
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    host.wr_reg(addr, data, ok);
    check("write ack", {7'h00, ok}, 8'h01);
  endtask
  task automatic rdchk(input string name, input logic [7:0] addr, input logic [7:0] exp);
    host.rd_reg(addr, rd, ok);
    check(name, rd, exp);
  endtask
  // open drain and drive-low are active low; only drive-high is active high
  function automatic logic active();
    return irq_oe === 1'b1 && irq_o === (cur_style == vdiu_pkg::STYLE_HIGH);
  endfunction
  task automatic measure(output int len);
    int w;
    len = 0;
    w = 0;
    while (!active() && w < 100) begin
      @(negedge clk);
      w++;
    end
    while (active() && len < 200) begin
      @(negedge clk);
      len++;
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    lock_state = 1'b0;
    freerun_state = 1'b0;
    pseudo_sync_det = 1'b0;
    colour_stripe_det = 1'b0;
    cur_style = 2'h0;
    n_fail = 0;
    checks = 0;
    durs = '{vdiu_pkg::DUR_SHORT_CYC, vdiu_pkg::DUR_MID_CYC, vdiu_pkg::DUR_LONG_CYC};
    repeat (8) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    repeat (10) @(negedge clk);
    check("irq idle oe", {7'h00, irq_oe}, 8'h00);
    check("sda out", {7'h00, sda_o}, 8'h00);
    wr(vdiu_pkg::ADDR_PIN_CFG, 8'h31);
    wr(vdiu_pkg::ADDR_USR_CTRL, {6'h00, vdiu_pkg::SUBMAP_INTR});
    rdchk("user ctrl", vdiu_pkg::ADDR_USR_CTRL, 8'h01);
    rdchk("cfg before select", vdiu_pkg::ADDR_PIN_CFG, vdiu_pkg::PIN_CFG_RST);
    rdchk("status reset", vdiu_pkg::ADDR_STAT1, vdiu_pkg::STAT_RST);
    rdchk("clear reads zero", vdiu_pkg::ADDR_CLR1, 8'h00);
    rdchk("unmapped", 8'h50, 8'h00);
    // reserved style, hold length and manual bit all at once
    wr(vdiu_pkg::ADDR_PIN_CFG, 8'hff);
    rdchk("cfg rw", vdiu_pkg::ADDR_PIN_CFG, vdiu_pkg::PIN_CFG_WMASK);
    check("manual irq on", {7'h00, active()}, 8'h01);
    wr(vdiu_pkg::ADDR_PIN_CFG, 8'hf0);
    repeat (4) @(negedge clk);
    check("manual irq off", {7'h00, irq_oe}, 8'h00);
    wr(vdiu_pkg::ADDR_MASK1, vdiu_pkg::STAT_USED);
    for (int k = 0; k < 3; k++) begin
      cur_style = k[1:0];
      wr(vdiu_pkg::ADDR_PIN_CFG, {k[1:0], 2'h3, 2'h0, k[1:0]});
      repeat (4) @(negedge clk);
      check("irq idle", {6'h00, irq_oe, irq_o}, (k == 0) ? 8'h00 : {7'h01, k == 1});
      lock_state = !lock_state;
      measure(n);
      check("pulse length", n[7:0], durs[k][7:0]);
      rdchk("lock status", vdiu_pkg::ADDR_STAT1, lock_state ? 8'h01 : 8'h02);
      wr(vdiu_pkg::ADDR_CLR1, vdiu_pkg::STAT_USED);
      rdchk("status cleared", vdiu_pkg::ADDR_STAT1, 8'h00);
    end
    cur_style = vdiu_pkg::STYLE_LOW;
    wr(vdiu_pkg::ADDR_PIN_CFG, 8'hf1);
    @(negedge clk) freerun_state = 1'b1;
    repeat (80) @(negedge clk);
    check("hold active", {7'h00, active()}, 8'h01);
    rdchk("freerun status", vdiu_pkg::ADDR_STAT1, 8'h20);
    wr(vdiu_pkg::ADDR_STAT1, 8'h00);
    rdchk("status read only", vdiu_pkg::ADDR_STAT1, 8'h20);
    wr(vdiu_pkg::ADDR_CLR1, 8'h83);
    rdchk("clear zero keeps", vdiu_pkg::ADDR_STAT1, 8'h20);
    wr(vdiu_pkg::ADDR_CLR1, 8'h20);
    repeat (4) @(negedge clk);
    check("hold released", {7'h00, active()}, 8'h00);
    wr(vdiu_pkg::ADDR_MASK1, 8'h00);
    @(negedge clk) freerun_state = 1'b0;
    measure(n);
    check("masked no pulse", n[7:0], 8'h00);
    rdchk("masked status", vdiu_pkg::ADDR_STAT1, 8'h20);
    wr(vdiu_pkg::ADDR_CLR1, 8'h20);
    for (int s = 0; s < 4; s++) begin
      wr(vdiu_pkg::ADDR_PIN_CFG, {2'h0, s[1:0], 4'h1});
      for (int d = 0; d < 2; d++) begin
        @(negedge clk);
        if (d == 0) pseudo_sync_det = 1'b1;
        else colour_stripe_det = 1'b1;
        @(negedge clk);
        pseudo_sync_det = 1'b0;
        colour_stripe_det = 1'b0;
        rdchk("copy protect", vdiu_pkg::ADDR_STAT1, s[d] ? 8'h40 : 8'h00);
        wr(vdiu_pkg::ADDR_CLR1, 8'h40);
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
